// *** src/mmt_pkg.sv ***
// Package of constants for the multi-mode timer with real-time output unit
package mmt_pkg;
  // ----------------------------------------
  // Sizes and block numbering
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int NUM_TMR = 5;
  localparam int WDT_IDX = 2;
  localparam int XT_IDX = 3;
  localparam int NUM_PIN = 4;
  localparam int NUM_RTO = 4;
  localparam logic [2:0] RTO_BLK = 3'h5;
  // ----------------------------------------
  // Register offsets inside a block
  // ----------------------------------------
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_EMU = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h10;
  localparam logic [7:0] OFF_CNT_HI = 8'h14;
  localparam logic [7:0] OFF_PRD_LO = 8'h18;
  localparam logic [7:0] OFF_PRD_HI = 8'h1c;
  localparam logic [7:0] OFF_TCTL = 8'h20;
  localparam logic [7:0] OFF_GCTL = 8'h24;
  localparam logic [7:0] OFF_WDCTL = 8'h28;
  localparam logic [7:0] OFF_REL_LO = 8'h34;
  localparam logic [7:0] OFF_REL_HI = 8'h38;
  localparam logic [7:0] OFF_CAP_LO = 8'h3c;
  localparam logic [7:0] OFF_CAP_HI = 8'h40;
  localparam logic [7:0] OFF_IRQ = 8'h44;
  localparam logic [7:0] OFF_RREV = 8'h00;
  localparam logic [7:0] OFF_RCTL = 8'h04;
  // ----------------------------------------
  // Field positions and encodings
  // ----------------------------------------
  localparam int TC_ML = 0;
  localparam int TC_MH = 2;
  localparam int TC_EXT = 4;
  localparam int TC_CAP = 5;
  localparam int TC_RRS = 6;
  localparam int TC_PIN = 7;
  localparam int TC_W = 9;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_ONCE = 2'h1;
  localparam logic [1:0] OM_CONT = 2'h2;
  localparam logic [1:0] OM_RELOAD = 2'h3;
  localparam logic [1:0] GM_64 = 2'h0;
  localparam logic [1:0] GM_CHAIN = 2'h2;
  localparam int IC_LEN = 0;
  localparam int IC_LST = 1;
  localparam int IC_HEN = 2;
  localparam int IC_HST = 3;
  localparam int WD_EN = 0;
  localparam int WD_SVC = 1;
  localparam int RC_SEL = 4;
  localparam int RC_EN = 5;
  // ----------------------------------------
  // Reset values and identity
  // ----------------------------------------
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] PRD_RST = 32'hffff_ffff;
  localparam logic [TC_W-1:0] TC_RST = 9'h000;
  // Identity values are arbitrary
  localparam logic [31:0] IDENT_VAL = 32'h0001_0001;
  localparam logic [31:0] REV_VAL = 32'h0002_0001;
endpackage

// *** src/mmt_top.sv ***
// Four general timers, one watchdog timer and a real-time output unit
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
// Overview of operation
// - Timers 0,1,3,4: 64-bit or dual 32-bit
// - 64-bit mode counts up across both halves
// - Timer 2 is watchdog, drives reset
// - One-time mode: one period then stop
// - Continuous mode: wrap to zero, keep counting
// - Timer 3 reload period at each boundary
// - Timer 3 counts internal or external clock
// - Any of four pins selects timer 3 clock
// - Timer 3 captures count on input event
// - Timer 3 counter read can clear counter
// - Timers raise interrupts to processor
// - Timers raise DMA sync events
// - Timer 3 event triggers the output unit
// - Four outputs change only on trigger
// - Trigger is lower or upper half event
// - Counter registers per half, read/write
// - Period registers per half set terminal
// - Reload registers per half
// - Capture registers per half
module mmt_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [mmt_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [mmt_pkg::NUM_PIN-1:0] ext_clock_pin,
  output logic [mmt_pkg::NUM_TMR-1:0] irq_lo,
  output logic [mmt_pkg::NUM_TMR-1:0] irq_hi,
  output logic [mmt_pkg::NUM_TMR-1:0] dma_lo,
  output logic [mmt_pkg::NUM_TMR-1:0] dma_hi,
  output logic wdt_reset,
  output logic [mmt_pkg::NUM_RTO-1:0] rto_out
);
  import mmt_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [2:0] blk = addr[10:8];
  wire [7:0] off = addr[7:0];
  logic [31:0] rdv [NUM_TMR];
  logic [NUM_TMR-1:0] ev_lo;
  logic [NUM_TMR-1:0] ev_hi;
  logic [NUM_TMR-1:0] gl_lo;
  logic [NUM_TMR-1:0] gl_hi;
  logic [31:0] rd_data_reg;
  logic [NUM_TMR-1:0] irq_lo_reg;
  logic [NUM_TMR-1:0] irq_hi_reg;
  logic [NUM_TMR-1:0] dma_lo_reg;
  logic [NUM_TMR-1:0] dma_hi_reg;
  logic wdt_reset_reg;
  logic [NUM_RTO-1:0] rto_out_reg;
  logic [5:0] rto_ctl_reg;

  function automatic logic acc(input logic [2:0] b, input logic [7:0] o,
                               input logic [2:0] tb, input logic [7:0] to);
    acc = (b == tb) && (o == to);
  endfunction

  // ----------------------------------------
  // External pin synchronisers
  // ----------------------------------------
  logic [NUM_PIN-1:0] pin_s1_reg;
  logic [NUM_PIN-1:0] pin_s2_reg;
  logic [NUM_PIN-1:0] pin_s3_reg;
  logic [TC_W-1:0] xt_tc;
  wire [1:0] pin_sel = xt_tc[TC_PIN +: 2];
  wire ext_lvl = pin_s2_reg[pin_sel];
  wire ext_old = pin_s3_reg[pin_sel];
  // Rising edge only, so a level that dwells does not count twice
  wire ext_rise = ext_lvl & ~ext_old;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= ext_clock_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // ----------------------------------------
  // Timer blocks
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_TMR; i++) begin : g_tmr
      localparam logic [2:0] BI = 3'(i);
      localparam bit IS_WD = (i == WDT_IDX);
      localparam bit IS_XT = (i == XT_IDX);
      logic [31:0] cl_reg;
      logic [31:0] ch_reg;
      logic [31:0] pl_reg;
      logic [31:0] ph_reg;
      logic [31:0] rl_reg;
      logic [31:0] rh_reg;
      logic [31:0] kl_reg;
      logic [31:0] kh_reg;
      logic [TC_W-1:0] tc_reg;
      logic [1:0] gc_reg;
      logic [3:0] ic_reg;
      logic [1:0] wd_reg;
      logic em_reg;

      wire w_cl = wr_en && acc(blk, off, BI, OFF_CNT_LO);
      wire w_ch = wr_en && acc(blk, off, BI, OFF_CNT_HI);
      wire w_pl = wr_en && acc(blk, off, BI, OFF_PRD_LO);
      wire w_ph = wr_en && acc(blk, off, BI, OFF_PRD_HI);
      wire w_rl = wr_en && acc(blk, off, BI, OFF_REL_LO);
      wire w_rh = wr_en && acc(blk, off, BI, OFF_REL_HI);
      wire w_tc = wr_en && acc(blk, off, BI, OFF_TCTL);
      wire w_gc = wr_en && acc(blk, off, BI, OFF_GCTL);
      wire w_ic = wr_en && acc(blk, off, BI, OFF_IRQ);
      wire w_wd = wr_en && acc(blk, off, BI, OFF_WDCTL);
      wire w_em = wr_en && acc(blk, off, BI, OFF_EMU);
      wire r_cl = rd_en && acc(blk, off, BI, OFF_CNT_LO);

      // Watchdog is always one 64-bit counter
      wire m64 = IS_WD || (gc_reg == GM_64);
      wire chain = gc_reg == GM_CHAIN;
      wire [1:0] ml = IS_WD ? (wd_reg[WD_EN] ? OM_CONT : OM_OFF)
                            : tc_reg[TC_ML +: 2];
      wire [1:0] mh = tc_reg[TC_MH +: 2];
      wire tick = (IS_XT && tc_reg[TC_EXT]) ? ext_rise : 1'b1;
      wire hit64 = {ch_reg, cl_reg} == {ph_reg, pl_reg};
      wire hitl = cl_reg == pl_reg;
      wire hith = ch_reg == ph_reg;
      wire runl = (ml != OM_OFF) && tick;
      wire evl = runl && (m64 ? hit64 : hitl);
      wire runh = !m64 && (mh != OM_OFF) && (chain ? evl : tick);
      wire evh = runh && hith;
      // Reload exists on the timer with extra features only
      wire rld_l = IS_XT && evl && (ml == OM_RELOAD);
      wire rld_h = IS_XT && evh && (mh == OM_RELOAD);
      wire cap = IS_XT && tc_reg[TC_CAP] && ext_rise;
      wire rrs = IS_XT && tc_reg[TC_RRS] && r_cl;
      wire svc = IS_WD && w_wd && wr_data[WD_SVC];

      assign ev_lo[i] = evl;
      assign ev_hi[i] = evh;
      assign gl_lo[i] = evl && ic_reg[IC_LEN];
      assign gl_hi[i] = evh && ic_reg[IC_HEN];
      if (IS_XT) begin : g_xt
        assign xt_tc = tc_reg;
      end

      // Both half counters, or the whole 64-bit count
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cl_reg <= CNT_RST;
          ch_reg <= CNT_RST;
        end else if (ce) begin
          if (m64 && (rrs || svc)) begin
            {ch_reg, cl_reg} <= '0;
          end else if (m64 && runl) begin
            {ch_reg, cl_reg} <= hit64 ? '0 : {ch_reg, cl_reg} + 64'h1;
          end else begin
            if (rrs) begin
              cl_reg <= CNT_RST;
            end else if (runl) begin
              cl_reg <= hitl ? CNT_RST : cl_reg + 32'h0000_0001;
            end
            if (runh) begin
              ch_reg <= hith ? CNT_RST : ch_reg + 32'h0000_0001;
            end
          end
          if (w_cl) begin
            cl_reg <= wr_data;
          end
          if (w_ch) begin
            ch_reg <= wr_data;
          end
        end
      end

      // Period registers; a reload lands at the terminal event only
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pl_reg <= PRD_RST;
          ph_reg <= PRD_RST;
        end else if (ce) begin
          if (rld_l) begin
            pl_reg <= rl_reg;
          end
          if ((rld_l && m64) || rld_h) begin
            ph_reg <= rh_reg;
          end
          if (w_pl) begin
            pl_reg <= wr_data;
          end
          if (w_ph) begin
            ph_reg <= wr_data;
          end
        end
      end

      // Reload registers
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rl_reg <= PRD_RST;
          rh_reg <= PRD_RST;
        end else if (ce) begin
          if (w_rl) begin
            rl_reg <= wr_data;
          end
          if (w_rh) begin
            rh_reg <= wr_data;
          end
        end
      end

      // Capture keeps the count before the tick
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          kl_reg <= CNT_RST;
          kh_reg <= CNT_RST;
        end else if (ce) begin
          if (cap) begin
            kl_reg <= cl_reg;
            kh_reg <= ch_reg;
          end
        end
      end

      // Timer control; a software write wins over the once-stop
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          tc_reg <= TC_RST;
        end else if (ce) begin
          if (w_tc) begin
            tc_reg <= wr_data[TC_W-1:0];
          end else begin
            if (evl && ml == OM_ONCE) begin
              tc_reg[TC_ML +: 2] <= OM_OFF;
            end
            if (evh && mh == OM_ONCE) begin
              tc_reg[TC_MH +: 2] <= OM_OFF;
            end
          end
        end
      end

      // Global, watchdog and emulation control
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          gc_reg <= GM_64;
          wd_reg <= '0;
          em_reg <= 1'b0;
        end else if (ce) begin
          if (w_gc) begin
            gc_reg <= wr_data[1:0];
          end
          if (w_wd) begin
            wd_reg <= {1'b0, wr_data[WD_EN]};
          end
          if (w_em) begin
            em_reg <= wr_data[0];
          end
        end
      end

      // Interrupt control; hardware set wins over the clear
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ic_reg <= '0;
        end else if (ce) begin
          if (w_ic) begin
            ic_reg[IC_LEN] <= wr_data[IC_LEN];
            ic_reg[IC_HEN] <= wr_data[IC_HEN];
          end
          ic_reg[IC_LST] <= evl | (ic_reg[IC_LST] & ~(w_ic & wr_data[IC_LST]));
          ic_reg[IC_HST] <= evh | (ic_reg[IC_HST] & ~(w_ic & wr_data[IC_HST]));
        end
      end

      // Read selection
      assign rdv[i] =
        (off == OFF_IDENT)  ? IDENT_VAL :
        (off == OFF_EMU)    ? {31'h0, em_reg} :
        (off == OFF_CNT_LO) ? cl_reg :
        (off == OFF_CNT_HI) ? ch_reg :
        (off == OFF_PRD_LO) ? pl_reg :
        (off == OFF_PRD_HI) ? ph_reg :
        (off == OFF_TCTL)   ? {23'h0, tc_reg} :
        (off == OFF_GCTL)   ? {30'h0, gc_reg} :
        (off == OFF_WDCTL)  ? {30'h0, wd_reg} :
        (off == OFF_REL_LO) ? rl_reg :
        (off == OFF_REL_HI) ? rh_reg :
        (off == OFF_CAP_LO) ? kl_reg :
        (off == OFF_CAP_HI) ? kh_reg :
        (off == OFF_IRQ)    ? {28'h0, ic_reg} :
        32'h0000_0000;
    end
  endgenerate

  // ----------------------------------------
  // Real-time output unit
  // ----------------------------------------
  wire w_rc = wr_en && acc(blk, off, RTO_BLK, OFF_RCTL);
  wire rto_trig = rto_ctl_reg[RC_SEL] ? ev_hi[XT_IDX] : ev_lo[XT_IDX];
  wire [31:0] rto_rd =
    (off == OFF_RREV) ? REV_VAL :
    (off == OFF_RCTL) ? {22'h0, rto_out_reg, rto_ctl_reg} :
    32'h0000_0000;
  // Unmapped blocks read as zero
  wire [31:0] rd_next =
    (blk < 3'(NUM_TMR)) ? rdv[blk] :
    (blk == RTO_BLK) ? rto_rd :
    32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rto_ctl_reg <= '0;
    end else if (ce) begin
      if (w_rc) begin
        rto_ctl_reg <= wr_data[5:0];
      end
    end
  end

  // Pattern held until the next enabled trigger
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rto_out_reg <= '0;
    end else if (ce) begin
      if (rto_ctl_reg[RC_EN] && rto_trig) begin
        rto_out_reg <= rto_ctl_reg[NUM_RTO-1:0];
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_reg <= '0;
    end else if (ce) begin
      // Read data stands for one cycle only
      rd_data_reg <= rd_en ? rd_next : 32'h0000_0000;
    end
  end

  // Event outputs, one clock each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_lo_reg <= '0;
      irq_hi_reg <= '0;
      dma_lo_reg <= '0;
      dma_hi_reg <= '0;
      wdt_reset_reg <= 1'b0;
    end else if (ce) begin
      irq_lo_reg <= gl_lo;
      irq_hi_reg <= gl_hi;
      dma_lo_reg <= gl_lo;
      dma_hi_reg <= gl_hi;
      wdt_reset_reg <= ev_lo[WDT_IDX];
    end
  end

  assign rd_data = rd_data_reg;
  assign irq_lo = irq_lo_reg;
  assign irq_hi = irq_hi_reg;
  assign dma_lo = dma_lo_reg;
  assign dma_hi = dma_hi_reg;
  assign wdt_reset = wdt_reset_reg;
  assign rto_out = rto_out_reg;
endmodule

// *** src/mmt_top_unused_placeholder_removed.sv ***
// Intentionally empty file holding no design
`timescale 1ns/1ns

// *** dv/mmt_properties.sv ***
// Port-level assertions for the multi-mode timer block
`timescale 1ns/1ns
module mmt_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic [mmt_pkg::NUM_TMR-1:0] irq_lo,
  input wire logic [mmt_pkg::NUM_TMR-1:0] irq_hi,
  input wire logic [mmt_pkg::NUM_TMR-1:0] dma_lo,
  input wire logic [mmt_pkg::NUM_TMR-1:0] dma_hi,
  input wire logic wdt_reset,
  input wire logic [mmt_pkg::NUM_RTO-1:0] rto_out
);
  import mmt_pkg::*;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire t3_ev = irq_lo[XT_IDX] | irq_hi[XT_IDX];
  // Past reset excluded: reset itself may clear the outputs
  chk_rd_quiet: assert property (ce && !rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data not zero outside read slot");
  chk_dma_lo_pair: assert property (dma_lo == irq_lo)
    else $error("lower dma event differs from interrupt");
  chk_dma_hi_pair: assert property (dma_hi == irq_hi)
    else $error("upper dma event differs from interrupt");
  chk_rto_on_trig: assert property (!$past(sys_rst) && $changed(rto_out) |-> t3_ev)
    else $error("outputs changed without timer event");
  chk_rto_dma_tie: assert property (!$past(sys_rst) && $changed(rto_out) |->
    (dma_lo[XT_IDX] || dma_hi[XT_IDX]))
    else $error("outputs changed without half event");
  chk_freeze_rto: assert property (!ce |=> $stable(rto_out))
    else $error("outputs moved while frozen");
  chk_freeze_irq: assert property (!ce |=> $stable(irq_lo) && $stable(irq_hi))
    else $error("interrupts moved while frozen");
  chk_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> (irq_lo == '0 &&
    rto_out == '0 && !wdt_reset && rd_data == '0))
    else $error("outputs not cleared by reset");
  cov_rto_load: cover property (!$past(sys_rst) && $changed(rto_out));
  cov_chain_hi: cover property (irq_hi[1] && irq_lo[1]);
  cov_wdt: cover property (wdt_reset);
endmodule

bind mmt_top mmt_properties u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .rd_en(rd_en),
  .rd_data(rd_data), .irq_lo(irq_lo), .irq_hi(irq_hi), .dma_lo(dma_lo), .dma_hi(dma_hi),
  .wdt_reset(wdt_reset), .rto_out(rto_out));

// *** dv/mmt_pin_src.sv ***
// Far-side pin source: bursts of four event pulses on one selected pin
`timescale 1ns/1ns
module mmt_pin_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] sel,
  output logic [3:0] pin,
  output logic busy
);
  // Two high, two low: pin cycle of four clocks, idle pins stay low
  logic [4:0] ph = 5'h00;
  always_ff @(posedge clk) begin
    if (go && !busy) begin
      ph <= 5'h10;
    end else if (busy) begin
      ph <= ph - 5'h01;
    end
  end
  assign busy = (ph != 5'h00);
  assign pin = (busy && ph[1]) ? (4'h1 << sel) : 4'h0;
endmodule

// *** dv/mmt_tb_top.sv ***
// Self-checking bench for the multi-mode timer block
`timescale 1ns/1ns
module mmt_tb_top;
  import mmt_pkg::*;
  logic clk, sys_rst, ce, wr_en, rd_en, go, wdt_reset, busy;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [NUM_PIN-1:0] ext_clock_pin;
  logic [NUM_TMR-1:0] irq_lo, irq_hi, dma_lo, dma_hi;
  logic [NUM_RTO-1:0] rto_out;
  logic [1:0] psel;
  int err_total, compares, n;
  // Write flag, block, offset, data or expected read
  logic [43:0] rows [13] = '{
    {1'b0, 3'h0, OFF_IDENT, IDENT_VAL}, {1'b0, RTO_BLK, OFF_RREV, REV_VAL},
    {1'b0, 3'h0, OFF_PRD_LO, PRD_RST}, {1'b0, 3'h4, OFF_REL_HI, 32'hffff_ffff},
    {1'b0, 3'h3, OFF_CAP_LO, CNT_RST}, {1'b1, 3'h3, OFF_CAP_HI, 32'h5a5a_5a5a},
    {1'b0, 3'h3, OFF_CAP_HI, CNT_RST}, {1'b1, 3'h0, OFF_CNT_HI, 32'hdead_0001},
    {1'b0, 3'h0, OFF_CNT_HI, 32'hdead_0001}, {1'b1, 3'h2, OFF_REL_LO, 32'h0000_1111},
    {1'b0, 3'h2, OFF_REL_LO, 32'h0000_1111}, {1'b0, 3'h0, 8'h08, 32'h0000_0000},
    {1'b0, 3'h6, 8'h00, 32'h0000_0000}};
  mmt_top u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_clock_pin(ext_clock_pin),
    .irq_lo(irq_lo), .irq_hi(irq_hi), .dma_lo(dma_lo), .dma_hi(dma_hi),
    .wdt_reset(wdt_reset), .rto_out(rto_out));
  mmt_pin_src u_pins (.clk(clk), .go(go), .sel(psel), .pin(ext_clock_pin), .busy(busy));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [10:0] ra(input logic [2:0] b, input logic [7:0] o);
    return {b, o};
  endfunction
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk32(rd_data, e);
  endtask
  function automatic logic sig(input int k);
    return k < 5 ? irq_lo[k] : (k < 10 ? irq_hi[k-5] : wdt_reset);
  endfunction
  // Bounded wait for an event output, sampled mid-cycle
  task automatic wait_sig(input int k);
    int m;
    m = 0;
    @(negedge clk);
    while (sig(k) !== 1'b1 && m < 300) begin
      @(negedge clk);
      m++;
    end
    chk1(sig(k), 1'b1);
  endtask
  task automatic test_done();
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {sys_rst, ce, wr_en, rd_en, go, psel, addr, wr_data} = {5'b11000, 2'h0, 11'h0, 32'h0};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][43]) wr(rows[i][42:32], rows[i][31:0]);
      else rd(rows[i][42:32], rows[i][31:0]);
    end
    wr(ra(3'h0, OFF_GCTL), 32'h1);
    wr(ra(3'h0, OFF_IRQ), 32'h1);
    wr(ra(3'h0, OFF_PRD_LO), 32'h2);
    wr(ra(3'h0, OFF_TCTL), 32'h2);
    wait_sig(0);
    repeat (2) begin
      @(negedge clk);
      chk1(irq_lo[0], 1'b0);
    end
    @(negedge clk);
    chk1(irq_lo[0], 1'b1);
    rd(ra(3'h0, OFF_IRQ), 32'h3);
    wr(ra(3'h0, OFF_TCTL), 32'h0);
    wr(ra(3'h1, OFF_GCTL), 32'h1);
    wr(ra(3'h1, OFF_IRQ), 32'h1);
    wr(ra(3'h1, OFF_PRD_LO), 32'h1);
    wr(ra(3'h1, OFF_TCTL), 32'h1);
    wait_sig(1);
    repeat (10) begin
      @(negedge clk);
      chk1(irq_lo[1], 1'b0);
    end
    rd(ra(3'h1, OFF_TCTL), 32'h0);
    wr(ra(3'h1, OFF_GCTL), 32'h2);
    wr(ra(3'h1, OFF_PRD_LO), 32'h3);
    wr(ra(3'h1, OFF_PRD_HI), 32'h0);
    wr(ra(3'h1, OFF_IRQ), 32'h5);
    wr(ra(3'h1, OFF_TCTL), 32'ha);
    wait_sig(6);
    repeat (12) begin
      @(negedge clk);
      chk1(irq_hi[1], irq_lo[1]);
    end
    wr(ra(3'h1, OFF_TCTL), 32'h0);
    wr(ra(3'h4, OFF_CNT_LO), 32'hffff_fffe);
    wr(ra(3'h4, OFF_TCTL), 32'h2);
    wr(ra(3'h4, OFF_TCTL), 32'h0);
    rd(ra(3'h4, OFF_CNT_HI), 32'h1);
    for (int p = 0; p < NUM_PIN; p++) begin
      wr(ra(3'h3, OFF_CNT_LO), 32'h0);
      wr(ra(3'h3, OFF_TCTL), 32'h32 | 32'(p << TC_PIN));
      @(posedge clk);
      psel <= 2'(p);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      for (n = 0; busy && n < 40; n++) @(posedge clk);
      repeat (5) @(posedge clk);
      wr(ra(3'h3, OFF_TCTL), 32'h0);
      rd(ra(3'h3, OFF_CNT_LO), 32'h4);
      rd(ra(3'h3, OFF_CAP_LO), 32'h3);
    end
    wr(ra(3'h3, OFF_CNT_LO), 32'h0000_1234);
    wr(ra(3'h3, OFF_TCTL), 32'h40);
    rd(ra(3'h3, OFF_CNT_LO), 32'h0000_1234);
    rd(ra(3'h3, OFF_CNT_LO), 32'h0);
    wr(ra(3'h3, OFF_GCTL), 32'h1);
    wr(ra(3'h3, OFF_PRD_LO), 32'h1);
    wr(ra(3'h3, OFF_REL_LO), 32'h3);
    wr(ra(3'h3, OFF_IRQ), 32'h1);
    wr(ra(RTO_BLK, OFF_RCTL), 32'h2a);
    wr(ra(3'h3, OFF_TCTL), 32'h3);
    wait_sig(3);
    chk32({28'h0, rto_out}, 32'ha);
    wait_sig(3);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq_lo[3] !== 1'b1 && n < 20);
    chk32(32'(n), 32'h4);
    wr(ra(RTO_BLK, OFF_RCTL), 32'h35);
    wait_sig(3);
    chk32({28'h0, rto_out}, 32'ha);
    rd(ra(RTO_BLK, OFF_RCTL), 32'h2b5);
    wr(ra(3'h3, OFF_PRD_HI), 32'h1);
    wr(ra(3'h3, OFF_IRQ), 32'h5);
    wr(ra(3'h3, OFF_TCTL), 32'hb);
    wait_sig(8);
    chk32({28'h0, rto_out}, 32'h5);
    wr(ra(3'h3, OFF_TCTL), 32'h0);
    wr(ra(3'h2, OFF_CNT_HI), 32'hffff_ffff);
    wr(ra(3'h2, OFF_CNT_LO), 32'hffff_fffc);
    wr(ra(3'h2, OFF_WDCTL), 32'h1);
    wait_sig(10);
    wr(ra(3'h2, OFF_WDCTL), 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    rd(ra(3'h0, OFF_IDENT), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(ra(3'h0, OFF_CNT_HI), CNT_RST);
    test_done();
  end
endmodule
